// file: design/serial_port_regs.vh
// Register offsets, field positions, reset values and timing counts of the serial port control block.
// Assumes a 32-bit APB slave at 100 MHz; byte offsets are word aligned.
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

`define OFF_CONTROL_COMMAND 8'h00
`define OFF_MODE_CONFIG 8'h04
`define OFF_IRQ_ENABLE_SET 8'h08
`define OFF_IRQ_DISABLE_SET 8'h0C
`define OFF_IRQ_MASK_VIEW 8'h10
`define OFF_CHANNEL_STATUS 8'h14
`define OFF_RX_HOLDING 8'h18
`define OFF_TX_HOLDING 8'h1C
`define OFF_BAUD_DIVIDER 8'h20
`define OFF_RX_TIMEOUT_CONFIG 8'h24
`define OFF_TX_TIMEGUARD 8'h28
`define OFF_ERROR_COUNT 8'h44
`define OFF_WRITE_PROTECT_CONFIG 8'hE4
`define OFF_WRITE_PROTECT_STATUS 8'hE8

// Control command bits
`define CMD_RX_RESET 2
`define CMD_TX_RESET 3
`define CMD_RX_EN 4
`define CMD_RX_DIS 5
`define CMD_TX_EN 6
`define CMD_TX_DIS 7
`define CMD_CLR_STATUS 8
`define CMD_START_BREAK 9
`define CMD_STOP_BREAK 10
`define CMD_TIMEOUT_ARM 11
`define CMD_SEND_ADDR 12
`define CMD_TIMEOUT_RESTART 15
`define CMD_RTS_SET 18
`define CMD_RTS_CLEAR 19

// Mode fields
`define MODE_OP_LSB 0
`define MODE_OP_MSB 3
`define MODE_PAR_LSB 9
`define MODE_PAR_MSB 11
`define MODE_CHM_LSB 14
`define MODE_CHM_MSB 15
`define OP_NORMAL 4'h0
`define OP_HANDSHAKE 4'h2
`define OP_SPI_MASTER 4'hE
`define OP_SPI_SLAVE 4'hF
`define PAR_MULTIDROP 3'h6
`define CHM_NORMAL 2'h0
`define CHM_ECHO 2'h1
`define CHM_LOCAL 2'h2
`define CHM_REMOTE 2'h3

// Status bits
`define ST_RX_READY 0
`define ST_TX_READY 1
`define ST_BREAK_RX 2
`define ST_OVERRUN 5
`define ST_FRAMING 6
`define ST_PARITY 7
`define ST_TIMEOUT 8
`define ST_TX_EMPTY 9

// Protection
`define WP_KEY 24'h555341
`define WP_SRC_LSB 8
`define WP_CFG_RESET 32'h00000000

// Timing, in bit periods
`define BREAK_MIN_BITS 16'd10
`define BREAK_HIGH_BITS 16'd12
`define CHAR_BITS 4'd10

`endif

// file: design/serial_port_control.v
// Control, status, test-mode and write-protection logic of a serial port, with an APB slave.
// Assumes a one-cycle baud tick (bit_tick) and simple character strobes from the shift engines outside.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "serial_port_regs.vh"

module serial_port_control (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins and engine taps
  input wire rxd_pin,
  input wire tx_engine_out,
  input wire bit_tick,
  input wire slave_select_line,
  input wire rx_char_done,
  input wire [8:0] rx_char_data,
  input wire rx_parity_err,
  input wire rx_frame_err,
  input wire rx_break_seen,
  input wire tx_shift_empty,
  input wire tx_char_taken,
  // Outputs
  output reg txd_pin,
  output reg receiver_in,
  output reg rts_pin,
  output reg rx_enabled,
  output reg tx_enabled,
  output reg rx_reset_pulse,
  output reg tx_reset_pulse,
  output reg break_active,
  output reg tx_char_valid,
  output reg [8:0] tx_char_data,
  output reg tx_addr_bit,
  output reg spi_rx_start
);

  reg [31:0] mode_r;
  reg [31:0] baud_r;
  reg [31:0] rto_r;
  reg [31:0] ttg_r;
  reg [31:0] imr_r;
  reg [8:0] rhr_r;
  reg rx_ready_r, overrun_r, parity_r, framing_r, brk_rx_r, timeout_r;
  reg wp_en_r, wp_viol_r;
  reg [7:0] wp_src_r;
  reg send_addr_r;
  reg [16:0] to_cnt_r;
  reg to_run_r, to_wait_r;
  reg brk_pend_r, brk_stop_r;
  reg [1:0] brk_state_r;
  reg [15:0] brk_cnt_r;

  localparam BRK_IDLE = 2'd0;
  localparam BRK_LOW = 2'd1;
  localparam BRK_HIGH = 2'd2;

  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire [3:0] op = mode_r[`MODE_OP_MSB:`MODE_OP_LSB];
  wire [1:0] chm = mode_r[`MODE_CHM_MSB:`MODE_CHM_LSB];
  wire spi = (op == `OP_SPI_MASTER) || (op == `OP_SPI_SLAVE);
  wire protected_hit = (paddr == `OFF_MODE_CONFIG) || (paddr == `OFF_BAUD_DIVIDER) ||
    (paddr == `OFF_RX_TIMEOUT_CONFIG) || (paddr == `OFF_TX_TIMEGUARD) ||
    (paddr == `OFF_WRITE_PROTECT_CONFIG);
  wire blocked = wr & wp_en_r & protected_hit;
  wire wok = wr & ~blocked;
  // Command bits are decoded straight off the write and never held
  wire [31:0] cmd = (wok && paddr == `OFF_CONTROL_COMMAND) ? pwdata : 32'h00000000;
  wire thr_wr = wok && paddr == `OFF_TX_HOLDING;
  wire rx_live = rx_enabled && chm != `CHM_REMOTE;
  wire rx_evt = rx_char_done & rx_live & (~(op == `OP_SPI_SLAVE) | ~slave_select_line);
  wire tx_idle = ~tx_char_valid & tx_shift_empty;
  // Command strobes, one per control bit
  wire receiver_reset_cmd = cmd[`CMD_RX_RESET];
  wire transmitter_reset_cmd = cmd[`CMD_TX_RESET];
  wire receiver_enable_cmd = cmd[`CMD_RX_EN];
  wire receiver_disable_cmd = cmd[`CMD_RX_DIS];
  wire transmitter_enable_cmd = cmd[`CMD_TX_EN];
  wire transmitter_disable_cmd = cmd[`CMD_TX_DIS];
  wire clear_status_cmd = cmd[`CMD_CLR_STATUS];
  wire start_break_cmd = cmd[`CMD_START_BREAK];
  wire stop_break_cmd = cmd[`CMD_STOP_BREAK];
  wire timeout_arm_cmd = cmd[`CMD_TIMEOUT_ARM];
  wire send_address_cmd = cmd[`CMD_SEND_ADDR];
  wire timeout_restart_cmd = cmd[`CMD_TIMEOUT_RESTART];
  wire rts_set_cmd = cmd[`CMD_RTS_SET];
  wire rts_clear_cmd = cmd[`CMD_RTS_CLEAR];
  // Status word; reserved bits read as zero
  wire [31:0] status_word = {
    22'h00000,
    tx_idle & tx_enabled,
    timeout_r,
    parity_r,
    framing_r,
    overrun_r,
    2'b00,
    brk_rx_r,
    ~tx_char_valid & tx_enabled,
    rx_ready_r
  };
  // Protection status: offending register in 15:8, flag in bit 0
  wire [31:0] wp_status_word = {
    16'h0000,
    wp_src_r,
    7'h00,
    wp_viol_r
  };

  // Zero-wait slave: pready rises at the first edge after reset and stays up,
  // so every access completes in its first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 32'h00000000;
      baud_r <= 32'h00000000;
      rto_r <= 32'h00000000;
      ttg_r <= 32'h00000000;
      imr_r <= 32'h00000000;
      wp_en_r <= 1'b0;
    end else if (wok) begin
      case (paddr)
        `OFF_MODE_CONFIG: mode_r <= pwdata;
        `OFF_BAUD_DIVIDER: baud_r <= pwdata;
        `OFF_RX_TIMEOUT_CONFIG: rto_r <= pwdata;
        `OFF_TX_TIMEGUARD: ttg_r <= pwdata;
        `OFF_IRQ_ENABLE_SET: imr_r <= imr_r | pwdata;
        `OFF_IRQ_DISABLE_SET: imr_r <= imr_r & ~pwdata;
        `OFF_WRITE_PROTECT_CONFIG: begin
          // A wrong key leaves protection as it was
          if (pwdata[31:8] == `WP_KEY)
            wp_en_r <= pwdata[0];
        end
        default: ;
      endcase
    end
  end

  // Protection violation: setting wins over the read that clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_viol_r <= 1'b0;
      wp_src_r <= 8'h00;
    end else if (blocked) begin
      wp_viol_r <= 1'b1;
      wp_src_r <= paddr;
    end else if (rd && paddr == `OFF_WRITE_PROTECT_STATUS) begin
      wp_viol_r <= 1'b0;
    end
  end

  // Enables and resets
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enabled <= 1'b0;
      tx_enabled <= 1'b0;
      rx_reset_pulse <= 1'b0;
      tx_reset_pulse <= 1'b0;
    end else begin
      rx_reset_pulse <= receiver_reset_cmd;
      tx_reset_pulse <= transmitter_reset_cmd;
      if (receiver_disable_cmd)
        rx_enabled <= 1'b0;
      else if (receiver_enable_cmd)
        rx_enabled <= 1'b1;
      if (transmitter_disable_cmd)
        tx_enabled <= 1'b0;
      else if (transmitter_enable_cmd)
        tx_enabled <= 1'b1;
    end
  end

  // Receive holding and status; a new event wins over a holding read or status clear in the same cycle, but a receiver reset wins over it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rhr_r <= 9'h000;
      rx_ready_r <= 1'b0;
      overrun_r <= 1'b0;
      parity_r <= 1'b0;
      framing_r <= 1'b0;
      brk_rx_r <= 1'b0;
    end else begin
      if (rd && paddr == `OFF_RX_HOLDING)
        rx_ready_r <= 1'b0;
      if (clear_status_cmd) begin
        overrun_r <= 1'b0;
        parity_r <= 1'b0;
        framing_r <= 1'b0;
        brk_rx_r <= 1'b0;
      end
      if (receiver_reset_cmd)
        rx_ready_r <= 1'b0;
      else if (rx_evt) begin
        rhr_r <= rx_char_data;
        rx_ready_r <= 1'b1;
        if (rx_ready_r)
          overrun_r <= 1'b1;
        if (rx_parity_err)
          parity_r <= 1'b1;
        if (rx_frame_err)
          framing_r <= 1'b1;
      end
      if (rx_live && rx_break_seen)
        brk_rx_r <= 1'b1;
    end
  end

  // Receiver timeout, counted in bit periods
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_r <= 17'h00000;
      to_run_r <= 1'b0;
      to_wait_r <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      if (timeout_arm_cmd) begin
        timeout_r <= 1'b0;
        to_run_r <= 1'b0;
        to_wait_r <= 1'b1;
      end else if (timeout_restart_cmd) begin
        to_run_r <= 1'b1;
        to_cnt_r <= rto_r[16:0];
      end else if (rx_evt) begin
        to_wait_r <= 1'b0;
        to_run_r <= 1'b1;
        to_cnt_r <= rto_r[16:0];
      end else if (to_run_r && bit_tick && !spi && rto_r[16:0] != 17'h00000) begin
        // The baud clock stops between SPI transfers, so the count never elapses there
        if (to_cnt_r <= 17'h00001) begin
          timeout_r <= 1'b1;
          to_run_r <= 1'b0;
        end else
          to_cnt_r <= to_cnt_r - 17'h00001;
      end
      if (spi)
        timeout_r <= 1'b0;
    end
  end

  // Transmit holding, address flag, break sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_char_valid <= 1'b0;
      tx_char_data <= 9'h000;
      tx_addr_bit <= 1'b0;
      send_addr_r <= 1'b0;
      brk_pend_r <= 1'b0;
      brk_stop_r <= 1'b0;
      brk_state_r <= BRK_IDLE;
      brk_cnt_r <= 16'h0000;
      break_active <= 1'b0;
    end else begin
      if (send_address_cmd && mode_r[`MODE_PAR_MSB:`MODE_PAR_LSB] == `PAR_MULTIDROP)
        send_addr_r <= 1'b1;
      if (transmitter_reset_cmd || !tx_enabled)
        tx_char_valid <= 1'b0;
      else if (thr_wr && !tx_char_valid) begin
        tx_char_valid <= 1'b1;
        tx_char_data <= pwdata[8:0];
        tx_addr_bit <= send_addr_r;
        send_addr_r <= 1'b0;
      end else if (tx_char_taken)
        tx_char_valid <= 1'b0;
      if (start_break_cmd && brk_state_r == BRK_IDLE)
        brk_pend_r <= 1'b1;
      if (stop_break_cmd && brk_state_r == BRK_LOW)
        brk_stop_r <= 1'b1;
      case (brk_state_r)
        BRK_IDLE: begin
          if (brk_pend_r && tx_idle) begin
            brk_state_r <= BRK_LOW;
            brk_pend_r <= 1'b0;
            brk_cnt_r <= 16'h0000;
            break_active <= 1'b1;
          end
        end
        BRK_LOW: begin
          if (bit_tick && brk_cnt_r < `BREAK_MIN_BITS)
            brk_cnt_r <= brk_cnt_r + 16'h0001;
          if (brk_stop_r && brk_cnt_r >= `BREAK_MIN_BITS) begin
            brk_state_r <= BRK_HIGH;
            brk_stop_r <= 1'b0;
            brk_cnt_r <= 16'h0000;
            break_active <= 1'b0;
          end
        end
        BRK_HIGH: begin
          if (bit_tick)
            brk_cnt_r <= brk_cnt_r + 16'h0001;
          if (brk_cnt_r >= `BREAK_HIGH_BITS)
            brk_state_r <= BRK_IDLE;
        end
        default: brk_state_r <= BRK_IDLE;
      endcase
      if (transmitter_reset_cmd) begin
        brk_state_r <= BRK_IDLE;
        brk_pend_r <= 1'b0;
        brk_stop_r <= 1'b0;
        break_active <= 1'b0;
      end
    end
  end

  // Channel routing and request-to-send
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_pin <= 1'b1;
      receiver_in <= 1'b1;
      rts_pin <= 1'b1;
      spi_rx_start <= 1'b0;
    end else begin
      spi_rx_start <= (op == `OP_SPI_SLAVE) & ~slave_select_line & rx_enabled;
      case (chm)
        `CHM_NORMAL: begin
          receiver_in <= rxd_pin;
          txd_pin <= break_active ? 1'b0 : tx_engine_out;
        end
        `CHM_ECHO: begin
          receiver_in <= rxd_pin;
          txd_pin <= rxd_pin;
        end
        `CHM_LOCAL: begin
          receiver_in <= tx_engine_out;
          txd_pin <= 1'b1;
        end
        `CHM_REMOTE: begin
          receiver_in <= 1'b1;
          txd_pin <= rxd_pin;
        end
        default: begin
          receiver_in <= 1'b1;
          txd_pin <= 1'b1;
        end
      endcase
      if (rts_set_cmd)
        rts_pin <= (op == `OP_HANDSHAKE) ? 1'b1 : 1'b0;
      else if (rts_clear_cmd)
        rts_pin <= (op == `OP_HANDSHAKE) ? 1'b0 : 1'b1;
    end
  end

  // Read data, registered in the setup cycle so it is valid in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFF_MODE_CONFIG: prdata <= mode_r;
        `OFF_IRQ_MASK_VIEW: prdata <= imr_r;
        `OFF_CHANNEL_STATUS: prdata <= status_word;
        `OFF_RX_HOLDING: prdata <= {23'h00000, rhr_r};
        `OFF_BAUD_DIVIDER: prdata <= baud_r;
        `OFF_RX_TIMEOUT_CONFIG: prdata <= rto_r;
        `OFF_TX_TIMEGUARD: prdata <= ttg_r;
        // The key is write-only and reads as zero, so the register reads zero after reset
        `OFF_WRITE_PROTECT_CONFIG: prdata <= {24'h000000, 7'h00, wp_en_r};
        `OFF_WRITE_PROTECT_STATUS: prdata <= wp_status_word;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// file: tb/serial_port_control_sva.sv
// Checker for serial_port_control: command pulses, channel routing and handshake pin.
// Assumes pready stays high, so each access phase lasts one cycle.
`timescale 1ns/100ps
`include "serial_port_regs.vh"
module serial_port_control_sva (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  // Line inputs
  input wire rxd_pin,
  input wire tx_engine_out,
  input wire slave_select_line,
  // Outputs watched
  input wire txd_pin,
  input wire receiver_in,
  input wire rts_pin,
  input wire rx_enabled,
  input wire tx_enabled,
  input wire rx_reset_pulse,
  input wire tx_reset_pulse,
  input wire break_active,
  input wire spi_rx_start
);
  wire wr_cmd = psel && penable && pwrite && paddr == `OFF_CONTROL_COMMAND;
  wire tx_rst_req = wr_cmd && pwdata[`CMD_TX_RESET];
  reg prot_r;
  reg run_r;
  reg [31:0] mode_r;
  reg [1:0] chm_d_r;
  // Mirror of the mode register; once protection is on it stays on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_r <= 1'b0;
      run_r <= 1'b0;
      mode_r <= 32'h00000000;
      chm_d_r <= 2'h0;
    end else begin
      run_r <= 1'b1;
      chm_d_r <= mode_r[`MODE_CHM_MSB:`MODE_CHM_LSB];
      if (psel && penable && pwrite && paddr == `OFF_WRITE_PROTECT_CONFIG && !prot_r && pwdata[31:8] == `WP_KEY)
        prot_r <= pwdata[0];
      if (psel && penable && pwrite && paddr == `OFF_MODE_CONFIG && !prot_r)
        mode_r <= pwdata;
    end
  end
  wire [1:0] chm = mode_r[`MODE_CHM_MSB:`MODE_CHM_LSB];
  wire [3:0] op = mode_r[`MODE_OP_MSB:`MODE_OP_LSB];
  // Routing is registered, so the first edge after reset still shows reset levels
  wire steady = run_r && chm == chm_d_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rx_reset; wr_cmd && pwdata[`CMD_RX_RESET] |=> rx_reset_pulse; endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receiver reset pulse missing");
  property p_tx_reset; tx_reset_pulse |-> $past(tx_rst_req); endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("stray transmitter reset pulse");
  property p_rx_en;
    wr_cmd && (pwdata[`CMD_RX_EN] || pwdata[`CMD_RX_DIS]) && !pwdata[`CMD_RX_RESET]
      |=> rx_enabled == !$past(pwdata[`CMD_RX_DIS]);
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("receiver enable wrong");
  property p_tx_en;
    wr_cmd && (pwdata[`CMD_TX_EN] || pwdata[`CMD_TX_DIS]) && !pwdata[`CMD_TX_RESET]
      |=> tx_enabled == !$past(pwdata[`CMD_TX_DIS]);
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("transmitter enable wrong");
  property p_normal;
    steady && chm == `CHM_NORMAL && !break_active && !$past(break_active)
      |-> txd_pin == $past(tx_engine_out) && receiver_in == $past(rxd_pin);
  endproperty
  a_normal: assert property (p_normal) else $error("normal routing wrong");
  property p_echo;
    steady && chm == `CHM_ECHO |-> txd_pin == $past(rxd_pin) && receiver_in == $past(rxd_pin);
  endproperty
  a_echo: assert property (p_echo) else $error("echo routing wrong");
  property p_local; steady && chm == `CHM_LOCAL |-> txd_pin && receiver_in == $past(tx_engine_out); endproperty
  a_local: assert property (p_local) else $error("local loopback routing wrong");
  property p_remote; steady && chm == `CHM_REMOTE |-> txd_pin == $past(rxd_pin); endproperty
  a_remote: assert property (p_remote) else $error("remote loopback routing wrong");
  property p_rts;
    wr_cmd && (pwdata[`CMD_RTS_SET] ^ pwdata[`CMD_RTS_CLEAR]) && op == `OP_HANDSHAKE
      |=> rts_pin == $past(pwdata[`CMD_RTS_SET]);
  endproperty
  a_rts: assert property (p_rts) else $error("request-to-send level wrong");
  property p_spi; (op == `OP_SPI_SLAVE && rx_enabled && !slave_select_line) [*3] |-> spi_rx_start; endproperty
  a_spi: assert property (p_spi) else $error("slave reception not started on low select");
  c_break: cover property (wr_cmd && pwdata[`CMD_START_BREAK]);
  c_local: cover property (steady && chm == `CHM_LOCAL);
  c_spi: cover property (spi_rx_start);
endmodule

// file: tb/line_partner.sv
// Far-side sender: drives the receive pin and select, and strobes the receive engine taps.
// Assumes bit_tick paces every bit; the idle line is pulled high.
`timescale 1ns/100ps
module line_partner (
  // Clock and pacing
  input wire logic pclk,
  input wire logic bit_tick,
  // Line
  output logic rxd_pin = 1'b1,
  output logic slave_select_line = 1'b1,
  // Receive engine taps
  output logic rx_char_done = 1'b0,
  output logic [8:0] rx_char_data = 9'h000,
  output logic rx_parity_err = 1'b0,
  output logic rx_frame_err = 1'b0
);
  task automatic tick;
    do @(posedge pclk); while (!bit_tick);
  endtask
  task automatic send(input logic [8:0] d, input logic pe, input logic fe);
    slave_select_line <= 1'b0;
    tick();
    for (int i = 8; i >= 0; i--) begin
      rxd_pin <= d[i];
      tick();
    end
    rx_char_data <= d;
    rx_parity_err <= pe;
    rx_frame_err <= fe;
    rx_char_done <= 1'b1;
    rxd_pin <= 1'b1;
    @(posedge pclk);
    // Select rises only after the character has completed
    slave_select_line <= 1'b1;
    // Stale data would hide a design that samples late
    rx_char_data <= ~d;
    rx_char_done <= 1'b0;
    tick();
  endtask
endmodule

// file: tb/testbench.sv
// Directed bench for serial_port_control over APB, with the line partner and checker.
// Assumes zero-wait APB answers and a bit tick every four clocks.
`timescale 1ns/100ps
`include "serial_port_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_engine_out = 0, bit_tick = 0;
  logic rx_break_seen = 0, tx_shift_empty = 1, tx_char_taken = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, rdv;
  logic [1:0] tk = 2'h0;
  logic slv = 1'b0;
  logic [7:0] zr [10] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h44, 8'hE4, 8'hE8};
  logic [7:0] pa [5] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'hE4};
  wire [31:0] prdata;
  wire [8:0] rx_char_data, tx_char_data;
  wire pready, pslverr, rxd_pin, slave_select_line, rx_char_done, rx_parity_err, rx_frame_err;
  wire txd_pin, receiver_in, rts_pin, rx_enabled, tx_enabled, rx_reset_pulse, tx_reset_pulse;
  wire break_active, tx_char_valid, tx_addr_bit, spi_rx_start;
  int err_count = 0, checks = 0, cyc = 0;
  serial_port_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rxd_pin, .tx_engine_out, .bit_tick, .slave_select_line, .rx_char_done, .rx_char_data,
    .rx_parity_err, .rx_frame_err, .rx_break_seen, .tx_shift_empty, .tx_char_taken, .txd_pin, .receiver_in,
    .rts_pin, .rx_enabled, .tx_enabled, .rx_reset_pulse, .tx_reset_pulse, .break_active, .tx_char_valid,
    .tx_char_data, .tx_addr_bit, .spi_rx_start);
  line_partner u_far (.pclk, .bit_tick, .rxd_pin, .slave_select_line, .rx_char_done, .rx_char_data,
    .rx_parity_err, .rx_frame_err);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    tk <= tk + 2'h1;
    bit_tick <= (tk == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    `CHK(rdv & m, e)
  endtask
  task automatic pulse_taken;
    tx_char_taken <= 1'b1;
    @(posedge pclk);
    tx_char_taken <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (zr[i]) rc(zr[i], 32'hFFFFFFFF, 32'h00000000);
    for (int i = 0; i < 3; i++) begin
      wr(8'h20 + 8'(4 * i), 32'h0000005A);
      rc(8'h20 + 8'(4 * i), 32'h000000FF, 32'h0000005A);
    end
    wr(8'h30, 32'hFFFFFFFF);
    rc(8'h30, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h00, 32'h00000050);
    `CHK({rx_enabled, tx_enabled}, 2'b11)
    wr(8'h00, 32'h00000000);
    `CHK({rx_enabled, tx_enabled}, 2'b11)
    wr(8'h00, 32'h000000F0);
    `CHK({rx_enabled, tx_enabled}, 2'b00)
    wr(8'h00, 32'h0000000C);
    wr(8'h00, 32'h00000050);
    u_far.send(9'h0A5, 1'b0, 1'b0);
    rc(8'h14, 32'h00000021, 32'h00000001);
    rc(8'h18, 32'h000001FF, 32'h000000A5);
    u_far.send(9'h03C, 1'b0, 1'b0);
    u_far.send(9'h1C3, 1'b1, 1'b1);
    rx_break_seen <= 1'b1;
    @(posedge pclk);
    rx_break_seen <= 1'b0;
    rc(8'h14, 32'h000000E5, 32'h000000E5);
    rc(8'h18, 32'h000001FF, 32'h000001C3);
    wr(8'h00, 32'h00000100);
    rc(8'h14, 32'h000000E5, 32'h00000000);
    wr(8'h24, 32'h00000003);
    wr(8'h00, 32'h00000800);
    repeat (40) @(posedge pclk);
    rc(8'h14, 32'h00000100, 32'h00000000);
    wr(8'h00, 32'h00008000);
    repeat (40) @(posedge pclk);
    rc(8'h14, 32'h00000100, 32'h00000100);
    wr(8'h00, 32'h00000800);
    rc(8'h14, 32'h00000100, 32'h00000000);
    for (int m = 0; m < 4; m++) begin
      wr(8'h04, 32'(m) << 14);
      repeat (2) @(posedge pclk);
      `CHK(txd_pin, m != 0)
      if (m < 3) `CHK(receiver_in, m != 2)
    end
    for (int k = 2; k >= 0; k -= 2) begin
      wr(8'h04, 32'(k));
      wr(8'h00, 32'h00040000);
      `CHK(rts_pin, k == 2)
      wr(8'h00, 32'h00080000);
      `CHK(rts_pin, k == 0)
    end
    wr(8'h04, 32'h0000000F);
    wr(8'h00, 32'h00008000);
    u_far.send(9'h0F0, 1'b0, 1'b0);
    rc(8'h14, 32'h00000100, 32'h00000000);
    rc(8'h18, 32'h000001FF, 32'h000000F0);
    `CHK(spi_rx_start, 1'b0)
    wr(8'h04, 32'h00000C00);
    wr(8'h00, 32'h00001000);
    wr(8'h1C, 32'h00000041);
    `CHK({tx_char_valid, tx_addr_bit, tx_char_data}, {2'b11, 9'h041})
    pulse_taken();
    wr(8'h1C, 32'h00000042);
    `CHK({tx_char_valid, tx_addr_bit, tx_char_data}, {2'b10, 9'h042})
    // Transmitter idles high so the recovery period after a break reads the same
    tx_engine_out <= 1'b1;
    wr(8'h00, 32'h00000200);
    `CHK(break_active, 1'b0)
    pulse_taken();
    repeat (4) @(posedge pclk);
    `CHK(break_active, 1'b1)
    wr(8'h00, 32'h00000200);
    wr(8'h00, 32'h00000400);
    `CHK(break_active, 1'b1)
    repeat (150) @(posedge pclk);
    `CHK(break_active, 1'b0)
    wr(8'hE4, {`WP_KEY, 8'h01});
    foreach (pa[i]) begin
      wr(pa[i], 32'h00000000);
      `CHK(slv, 1'b0)
      rc(8'hE8, 32'h0000FFFF, {16'h0000, pa[i], 8'h01});
      rc(8'hE8, 32'h00000001, 32'h00000000);
    end
    rc(8'h24, 32'h000000FF, 32'h00000003);
    report_and_stop();
  end
endmodule
bind serial_port_control serial_port_control_sva u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rxd_pin(rxd_pin),
  .tx_engine_out(tx_engine_out), .slave_select_line(slave_select_line), .txd_pin(txd_pin),
  .receiver_in(receiver_in), .rts_pin(rts_pin), .rx_enabled(rx_enabled), .tx_enabled(tx_enabled),
  .rx_reset_pulse(rx_reset_pulse), .tx_reset_pulse(tx_reset_pulse), .break_active(break_active),
  .spi_rx_start(spi_rx_start));
